/* rtl/switch_node_routing_config.sv */
`default_nettype none
module switch_node_routing_config
  import switch_node_pkg::*;
#(
  // Identity values below are arbitrary.
  parameter logic [31:0] TEST_PORT_ID  = 32'h1234_5679,
  parameter logic [13:0] USER_OTP_CODE = 14'h0000,
  parameter logic [17:0] METAL_ID_CODE = 18'h0_0001
)
(
  // Clock and reset
  input  wire logic            i_ref_clk,
  input  wire logic            i_resetn,
  // Configuration access
  input  wire logic            i_cfg_wr,
  input  wire logic            i_cfg_rd,
  input  wire logic [7:0]      i_cfg_addr,
  input  wire logic [31:0]     i_cfg_wdata,
  output logic      [31:0]     o_cfg_rdata,
  output logic                 o_cfg_ack,
  // Routing lookup
  input  wire logic            i_pkt_valid,
  input  wire logic [15:0]     i_pkt_dest,
  output logic                 o_route_valid,
  output logic                 o_route_local,
  output logic      [3:0]      o_route_dir,
  output logic      [15:0]     o_node_id,
  // Node reference clock enable
  output logic                 o_ref_clk_en,
  // Shared debug line pad, active low
  input  wire logic            i_debug_pin_n,
  output logic                 o_debug_pin_n,
  output logic                 o_debug_pin_oe,
  input  wire logic [1:0]      i_core_halted_flag,
  output logic      [1:0]      o_debug_req,
  // External link status and fields
  input  wire logic [7:0][1:0] i_ext_kind,
  input  wire logic [7:0][7:0] i_ext_dest,
  input  wire logic [7:0][2:0] i_ext_flags,
  output logic      [7:0][3:0] o_ext_dir,
  output logic      [7:0][1:0] o_ext_net,
  // Processor link status and fields
  input  wire logic [7:0][1:0] i_proc_kind,
  input  wire logic [7:0][7:0] i_proc_dest,
  input  wire logic [7:0][2:0] i_proc_flags,
  output logic      [7:0][1:0] o_proc_net
);

  // ****************************************************************
  // Configuration decode
  // ****************************************************************
  logic        is_ext;
  logic        is_proc;
  logic        wr_link;
  logic [3:0]  link_idx;
  logic [5:0]  link_wdata;
  logic [5:0]  link_rdata;
  logic [15:0][5:0] link_fields;

  // accesses are taken only by register number on the config port.
  always_comb
  begin
    is_ext     = (i_cfg_addr[7:3] == ADDR_EXT_LINK0[7:3]);
    is_proc    = (i_cfg_addr[7:3] == ADDR_PROC_LINK0[7:3]);
    wr_link    = i_cfg_wr && (is_ext || is_proc);
    link_idx   = {is_proc, i_cfg_addr[2:0]};
    link_wdata = {i_cfg_wdata[LINK_NET_LSB +: 2], i_cfg_wdata[LINK_DIR_LSB +: 4]};
    // Processor links have no direction, so their entry keeps it at zero.
    if (is_proc)
    begin
      link_wdata[3:0] = 4'h0;
    end
  end

  link_field_store u_fields (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_wr_en   (wr_link),
    .i_wr_idx  (link_idx),
    .i_wr_data (link_wdata),
    .i_rd_idx  (link_idx),
    .o_rd_data (link_rdata),
    .o_fields  (link_fields)
  );

  always_comb
  begin
    for (int i = 0; i < NUM_LINKS; i++)
    begin
      o_ext_dir[i]  = link_fields[i][3:0];
      o_ext_net[i]  = link_fields[i][5:4];
      o_proc_net[i] = link_fields[i + NUM_LINKS][5:4];
    end
  end

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  logic [15:0] ref_div_r, ref_div_nxt;
  logic [15:0] node_id_r, node_id_nxt;
  logic [31:0] dir_lo_r, dir_lo_nxt;
  logic [31:0] dir_hi_r, dir_hi_nxt;
  logic [1:0]  dbg_cfg_r [NUM_TILES];
  logic [1:0]  dbg_cfg_nxt [NUM_TILES];
  logic [2:0]  origin_r, origin_nxt;
  logic        dbg_event;
  logic [2:0]  dbg_cause;

  always_comb
  begin
    ref_div_nxt    = ref_div_r;
    node_id_nxt    = node_id_r;
    dir_lo_nxt     = dir_lo_r;
    dir_hi_nxt     = dir_hi_r;
    dbg_cfg_nxt[0] = dbg_cfg_r[0];
    dbg_cfg_nxt[1] = dbg_cfg_r[1];
    origin_nxt     = origin_r;
    if (i_cfg_wr)
    begin
      case (i_cfg_addr)
        ADDR_REF_DIV:    ref_div_nxt = i_cfg_wdata[15:0];
        ADDR_NODE_ID:    node_id_nxt = i_cfg_wdata[15:0];
        ADDR_DIR_LOW:    dir_lo_nxt = i_cfg_wdata;
        ADDR_DIR_HIGH:   dir_hi_nxt = i_cfg_wdata;
        ADDR_DBG_CFG0:   dbg_cfg_nxt[0] = i_cfg_wdata[1:0];
        ADDR_DBG_CFG1:   dbg_cfg_nxt[1] = i_cfg_wdata[1:0];
        ADDR_DBG_ORIGIN: origin_nxt = {i_cfg_wdata[ORIGIN_PIN_BIT], i_cfg_wdata[1:0]};
        default:         origin_nxt = origin_r;
      endcase
    end
    // A new debug event overrides a software write in the same cycle.
    if (dbg_event)
    begin
      origin_nxt = dbg_cause;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ref_div_r    <= REF_DIV_RESET;
      node_id_r    <= NODE_ID_RESET;
      dir_lo_r     <= DIR_RESET;
      dir_hi_r     <= DIR_RESET;
      dbg_cfg_r[0] <= DBG_CFG_RESET;
      dbg_cfg_r[1] <= DBG_CFG_RESET;
      origin_r     <= DBG_ORIGIN_RESET;
    end
    else
    begin
      ref_div_r    <= ref_div_nxt;
      node_id_r    <= node_id_nxt;
      dir_lo_r     <= dir_lo_nxt;
      dir_hi_r     <= dir_hi_nxt;
      dbg_cfg_r[0] <= dbg_cfg_nxt[0];
      dbg_cfg_r[1] <= dbg_cfg_nxt[1];
      origin_r     <= origin_nxt;
    end
  end

  assign o_node_id = node_id_r;

  // ****************************************************************
  // Reference clock divider
  // ****************************************************************
  logic [15:0] div_cnt_r, div_cnt_nxt;
  logic        tick_r, tick_nxt;

  // A divider of zero behaves as one, so the tick never stops.
  always_comb
  begin
    tick_nxt    = 1'b0;
    div_cnt_nxt = div_cnt_r + 16'h0001;
    if ((div_cnt_r + 16'h0001) >= ref_div_r)
    begin
      div_cnt_nxt = 16'h0000;
      tick_nxt    = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      div_cnt_r <= 16'h0000;
      tick_r    <= 1'b0;
    end
    else
    begin
      div_cnt_r <= div_cnt_nxt;
      tick_r    <= tick_nxt;
    end
  end

  assign o_ref_clk_en = tick_r;

  // ****************************************************************
  // Routing lookup
  // ****************************************************************
  logic [15:0] mismatch;
  logic [3:0]  dim;
  logic [63:0] dir_table;
  logic        rv_r, rv_nxt;
  logic        rl_r, rl_nxt;
  logic [3:0]  rd_r, rd_nxt;

  always_comb
  begin
    mismatch  = i_pkt_dest ^ node_id_r;
    dir_table = {dir_hi_r, dir_lo_r};
    dim       = 4'h0;
    for (int b = 0; b < 16; b++)
    begin
      if (mismatch[b])
      begin
        dim = 4'(b);
      end
    end
    rv_nxt = i_pkt_valid;
    rl_nxt = rl_r;
    rd_nxt = rd_r;
    if (i_pkt_valid)
    begin
      rl_nxt = (mismatch == 16'h0000);
      rd_nxt = rl_nxt ? 4'h0 : dir_table[{dim, 2'b00} +: DIR_NIBBLE];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rv_r <= 1'b0;
      rl_r <= 1'b0;
      rd_r <= 4'h0;
    end
    else
    begin
      rv_r <= rv_nxt;
      rl_r <= rl_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign o_route_valid = rv_r;
  assign o_route_local = rl_r;
  assign o_route_dir   = rd_r;

  // ****************************************************************
  // Shared debug line
  // ****************************************************************
  logic       pin_s1_r, pin_s2_r;
  logic [2:0] oe_hist_r, oe_hist_nxt;
  logic       line_r, line_nxt;
  logic [1:0] req_r, req_nxt;
  logic [1:0] tile_drive;
  logic       ext_low;

  // The pad reads back our own drive two cycles late, so the external
  // source is masked while any recent drive could still be visible.
  always_comb
  begin
    for (int t = 0; t < NUM_TILES; t++)
    begin
      tile_drive[t] = i_core_halted_flag[t] & dbg_cfg_r[t][DBG_CFG_DRIVE_BIT];
      req_nxt[t]    = line_r & dbg_cfg_r[t][DBG_CFG_REQ_BIT];
    end
    oe_hist_nxt = {oe_hist_r[1:0], |tile_drive};
    ext_low     = ~pin_s2_r & ~(|oe_hist_r);
    line_nxt    = (|tile_drive) | ext_low;
    dbg_event   = line_nxt & ~line_r;
    dbg_cause   = {ext_low, tile_drive};
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pin_s1_r  <= 1'b1;
      pin_s2_r  <= 1'b1;
      oe_hist_r <= 3'h0;
      line_r    <= 1'b0;
      req_r     <= 2'h0;
    end
    else
    begin
      pin_s1_r  <= i_debug_pin_n;
      pin_s2_r  <= pin_s1_r;
      oe_hist_r <= oe_hist_nxt;
      line_r    <= line_nxt;
      req_r     <= req_nxt;
    end
  end

  assign o_debug_pin_n  = 1'b0;
  assign o_debug_pin_oe = oe_hist_r[0];
  assign o_debug_req    = req_r;

  // ****************************************************************
  // Read pipeline
  // ****************************************************************
  logic        s1_v_r, s1_rd_r;
  logic [7:0]  s1_addr_r;
  logic        ack_r;
  logic [31:0] rdata_r, rdata_nxt;
  logic [2:0]  li;
  logic [2:0]  flags;

  always_comb
  begin
    li        = s1_addr_r[2:0];
    flags     = s1_addr_r[6] ? i_proc_flags[li] : i_ext_flags[li];
    rdata_nxt = 32'h0000_0000;
    case (s1_addr_r)
      ADDR_NODE_ID:    rdata_nxt[15:0] = node_id_r;
      ADDR_REF_DIV:    rdata_nxt[15:0] = ref_div_r;
      ADDR_TEST_ID:    rdata_nxt = TEST_PORT_ID;
      ADDR_USER_CODE:  rdata_nxt = {USER_OTP_CODE, METAL_ID_CODE};
      ADDR_DIR_LOW:    rdata_nxt = dir_lo_r;
      ADDR_DIR_HIGH:   rdata_nxt = dir_hi_r;
      ADDR_DBG_CFG0:   rdata_nxt[1:0] = dbg_cfg_r[0];
      ADDR_DBG_CFG1:   rdata_nxt[1:0] = dbg_cfg_r[1];
      ADDR_DBG_ORIGIN: rdata_nxt = {27'h0, origin_r[2], 2'h0, origin_r[1:0]};
      default:
      begin
        if (s1_addr_r[7:3] == ADDR_EXT_LINK0[7:3]
            || s1_addr_r[7:3] == ADDR_PROC_LINK0[7:3])
        begin
          rdata_nxt[LINK_KIND_LSB +: 2] = s1_addr_r[6] ? i_proc_kind[li]
                                                       : i_ext_kind[li];
          rdata_nxt[LINK_DEST_LSB +: 8] = s1_addr_r[6] ? i_proc_dest[li]
                                                       : i_ext_dest[li];
          rdata_nxt[LINK_DIR_LSB +: 4]  = s1_addr_r[6] ? 4'h0 : link_rdata[3:0];
          rdata_nxt[LINK_NET_LSB +: 2]  = link_rdata[5:4];
          rdata_nxt[2:0]                = flags;
        end
      end
    endcase
    if (!s1_rd_r)
    begin
      rdata_nxt = rdata_r;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s1_v_r    <= 1'b0;
      s1_rd_r   <= 1'b0;
      s1_addr_r <= 8'h00;
      ack_r     <= 1'b0;
      rdata_r   <= 32'h0000_0000;
    end
    else
    begin
      s1_v_r    <= i_cfg_wr | i_cfg_rd;
      s1_rd_r   <= i_cfg_rd & ~i_cfg_wr;
      s1_addr_r <= i_cfg_addr;
      ack_r     <= s1_v_r;
      rdata_r   <= rdata_nxt;
    end
  end

  assign o_cfg_ack   = ack_r;
  assign o_cfg_rdata = rdata_r;

endmodule
`default_nettype wire

/* rtl/switch_node_pkg.sv */
`default_nettype none
package switch_node_pkg;

  // ****************************************************************
  // Register numbers
  // ****************************************************************
  localparam logic [7:0] ADDR_NODE_ID      = 8'h05;
  localparam logic [7:0] ADDR_REF_DIV      = 8'h08;
  localparam logic [7:0] ADDR_TEST_ID      = 8'h09;
  localparam logic [7:0] ADDR_USER_CODE    = 8'h0A;
  localparam logic [7:0] ADDR_DIR_LOW      = 8'h0C;
  localparam logic [7:0] ADDR_DIR_HIGH     = 8'h0D;
  localparam logic [7:0] ADDR_DBG_CFG0     = 8'h10;
  localparam logic [7:0] ADDR_DBG_CFG1     = 8'h11;
  localparam logic [7:0] ADDR_DBG_ORIGIN   = 8'h1F;
  localparam logic [7:0] ADDR_EXT_LINK0    = 8'h20;
  localparam logic [7:0] ADDR_PROC_LINK0   = 8'h40;
  localparam int         NUM_LINKS         = 8;
  localparam int         NUM_TILES         = 2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] REF_DIV_RESET    = 16'h0003;
  localparam logic [15:0] NODE_ID_RESET    = 16'h0000;
  localparam logic [31:0] DIR_RESET        = 32'h0000_0000;
  localparam logic [1:0]  DBG_CFG_RESET    = 2'h0;
  localparam logic [2:0]  DBG_ORIGIN_RESET = 3'h0;
  localparam logic [5:0]  LINK_FIELD_RESET = 6'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int DBG_CFG_REQ_BIT   = 1;
  localparam int DBG_CFG_DRIVE_BIT = 0;
  localparam int ORIGIN_PIN_BIT    = 4;
  localparam int ORIGIN_TILE1_BIT  = 1;
  localparam int ORIGIN_TILE0_BIT  = 0;
  localparam int LINK_KIND_LSB     = 24;
  localparam int LINK_DEST_LSB     = 16;
  localparam int LINK_DIR_LSB      = 8;
  localparam int LINK_NET_LSB      = 4;
  localparam int USER_CODE_LSB     = 18;
  localparam int DIR_NIBBLE        = 4;

  // Kinds of source target reported in a link status word.
  typedef enum logic [1:0] {
    TGT_SWITCH_EXTERNAL_PORT = 2'h0,
    TGT_PROCESSOR_PORT       = 2'h1,
    TGT_SWITCH_CONTROL       = 2'h2,
    TGT_UNDEFINED            = 2'h3
  } source_target_kind_t;

endpackage
`default_nettype wire

/* rtl/link_field_store.sv */
`default_nettype none
// Writable network fields of all link registers and direction fields of external links.
// Entries 0..7 are external links, 8..15 processor links.
module link_field_store
  import switch_node_pkg::*;
(
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_resetn,
  // Write port
  input  wire logic             i_wr_en,
  input  wire logic [3:0]       i_wr_idx,
  input  wire logic [5:0]       i_wr_data,
  // Read port
  input  wire logic [3:0]       i_rd_idx,
  output logic      [5:0]       o_rd_data,
  // Live field values
  output logic      [15:0][5:0] o_fields
);

  logic [15:0][5:0] mem_r;
  logic [15:0][5:0] mem_nxt;
  logic [5:0]       rd_r;
  logic [5:0]       rd_nxt;

  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_entry
      always_comb
      begin
        mem_nxt[g] = mem_r[g];
        if (i_wr_en && (i_wr_idx == 4'(g)))
        begin
          mem_nxt[g] = i_wr_data;
        end
      end

      always_ff @(posedge i_ref_clk or negedge i_resetn)
      begin
        if (!i_resetn)
        begin
          mem_r[g] <= LINK_FIELD_RESET;
        end
        else
        begin
          mem_r[g] <= mem_nxt[g];
        end
      end
    end
  endgenerate

  always_comb
  begin
    rd_nxt = mem_r[i_rd_idx];
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rd_r <= LINK_FIELD_RESET;
    end
    else
    begin
      rd_r <= rd_nxt;
    end
  end

  assign o_rd_data = rd_r;
  assign o_fields  = mem_r;

endmodule
`default_nettype wire

/* verif/switch_node_routing_config_asserts.sv */
`default_nettype none
module switch_node_routing_config_asserts
(
  // Clock and reset
  input wire logic            i_ref_clk,
  input wire logic            i_resetn,
  // Configuration access
  input wire logic            i_cfg_wr,
  input wire logic            i_cfg_rd,
  input wire logic [31:0]     o_cfg_rdata,
  input wire logic            o_cfg_ack,
  // Routing lookup
  input wire logic            i_pkt_valid,
  input wire logic [15:0]     i_pkt_dest,
  input wire logic            o_route_valid,
  input wire logic            o_route_local,
  input wire logic [3:0]      o_route_dir,
  input wire logic [15:0]     o_node_id,
  // Debug line
  input wire logic [1:0]      i_core_halted_flag,
  input wire logic            o_debug_pin_n,
  input wire logic            o_debug_pin_oe,
  input wire logic [1:0]      o_debug_req
);
  logic cfg_req;

  assign cfg_req = i_cfg_wr | i_cfg_rd;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);

  // ****************************************************************
  // Configuration port
  // ****************************************************************
  a_ack_latency: assert property (cfg_req |-> ##2 o_cfg_ack)
    else $error("config access not acknowledged two edges later");
  a_ack_cause: assert property (o_cfg_ack |-> $past(cfg_req, 2))
    else $error("acknowledge without a request");
  a_rdata_hold: assert property (!$stable(o_cfg_rdata) |-> o_cfg_ack)
    else $error("read data changed outside an acknowledge");

  // ****************************************************************
  // Routing lookup
  // ****************************************************************
  a_route_answer: assert property (i_pkt_valid |=> o_route_valid)
    else $error("lookup not answered one edge later");
  a_route_cause: assert property (o_route_valid |-> $past(i_pkt_valid))
    else $error("route valid without a lookup");
  a_route_local: assert property (i_pkt_valid |=>
    (o_route_local == ($past(i_pkt_dest) == $past(o_node_id))))
    else $error("local delivery flag wrong");
  a_local_dir_zero: assert property (o_route_valid && o_route_local |-> o_route_dir == 4'h0)
    else $error("local delivery with nonzero direction");
  a_route_hold: assert property (!$past(i_pkt_valid) |-> $stable({o_route_dir, o_route_local}))
    else $error("route result changed without a lookup");

  // ****************************************************************
  // Debug line
  // ****************************************************************
  a_oe_quiet: assert property ($past(i_core_halted_flag) == 2'b00 |-> !o_debug_pin_oe)
    else $error("debug line driven with no tile halted");
  a_pad_data_low: assert property (o_debug_pin_n == 1'b0)
    else $error("debug pad data not low");

  cover property (o_route_valid && o_route_local);
  cover property (o_debug_pin_oe);
  cover property (o_debug_req == 2'b11);
endmodule

bind switch_node_routing_config switch_node_routing_config_asserts u_chk (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd),
  .o_cfg_rdata(o_cfg_rdata), .o_cfg_ack(o_cfg_ack), .i_pkt_valid(i_pkt_valid),
  .i_pkt_dest(i_pkt_dest), .o_route_valid(o_route_valid), .o_route_local(o_route_local),
  .o_route_dir(o_route_dir), .o_node_id(o_node_id), .i_core_halted_flag(i_core_halted_flag),
  .o_debug_pin_n(o_debug_pin_n), .o_debug_pin_oe(o_debug_pin_oe), .o_debug_req(o_debug_req));
`default_nettype wire

/* verif/switch_node_routing_config_tb.sv */
`default_nettype none
module switch_node_routing_config_tb;
  import switch_node_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic                clk = 1'b0, rstn = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0;
  logic                pkt_valid = 1'b0, ext_pull_n = 1'b1, pad_n;
  logic [7:0]          cfg_addr = 8'h00;
  logic [31:0]         cfg_wdata = 32'h0000_0000, cfg_rdata;
  logic [15:0]         pkt_dest = 16'h0000, node_id;
  logic [1:0]          halted = 2'b00, debug_req;
  logic                cfg_ack, route_valid, route_local, ref_en, pin_n, pin_oe;
  logic [3:0]          route_dir;
  logic [7:0][1:0]     ext_kind, proc_kind, ext_net, proc_net;
  logic [7:0][7:0]     ext_dest, proc_dest;
  logic [7:0][2:0]     ext_flags, proc_flags;
  logic [7:0][3:0]     ext_dir;
  logic [63:0]         dirs = {32'h7654_3210, 32'hFEDC_BA98};
  logic [7:0]          unmapped [3] = '{8'h28, 8'h48, 8'h0B};
  int                  fails = 0, checks_done = 0, cycles = 0;

  // The pad is open drain: it reads low whenever this node pulls it.
  assign pad_n = pin_oe ? pin_n : ext_pull_n;

  always #10 clk = ~clk;

  // Identity values below are arbitrary.
  switch_node_routing_config #(.TEST_PORT_ID(32'h0A5C_3E71), .USER_OTP_CODE(14'h1A2B),
    .METAL_ID_CODE(18'h2_C3D4)) u_dut (
    .i_ref_clk(clk), .i_resetn(rstn), .i_cfg_wr(cfg_wr), .i_cfg_rd(cfg_rd),
    .i_cfg_addr(cfg_addr), .i_cfg_wdata(cfg_wdata), .o_cfg_rdata(cfg_rdata), .o_cfg_ack(cfg_ack),
    .i_pkt_valid(pkt_valid), .i_pkt_dest(pkt_dest), .o_route_valid(route_valid),
    .o_route_local(route_local), .o_route_dir(route_dir), .o_node_id(node_id),
    .o_ref_clk_en(ref_en), .i_debug_pin_n(pad_n), .o_debug_pin_n(pin_n), .o_debug_pin_oe(pin_oe),
    .i_core_halted_flag(halted), .o_debug_req(debug_req), .i_ext_kind(ext_kind),
    .i_ext_dest(ext_dest), .i_ext_flags(ext_flags), .o_ext_dir(ext_dir), .o_ext_net(ext_net),
    .i_proc_kind(proc_kind), .i_proc_dest(proc_dest), .i_proc_flags(proc_flags),
    .o_proc_net(proc_net));

  // ****************************************************************
  // Checking and access tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    int n;
    @(posedge clk);
    #1;
    cfg_wr = w;
    cfg_rd = !w;
    cfg_addr = a;
    cfg_wdata = d;
    @(posedge clk);
    #1;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    n = 1;
    while (cfg_ack !== 1'b1 && n < 10)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check("ack latency", 32'(n), 32'h0000_0002);
    r = cfg_rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0000_0000, r);
    check(what, r, e);
  endtask

  task automatic look(input logic [15:0] dest, input logic loc, input logic [3:0] dir);
    @(posedge clk);
    #1;
    pkt_valid = 1'b1;
    pkt_dest = dest;
    @(posedge clk);
    #1;
    pkt_valid = 1'b0;
    check("route valid", 32'(route_valid), 32'h0000_0001);
    check("route local", 32'(route_local), 32'(loc));
    check("route dir", 32'(route_dir), 32'(dir));
  endtask

  // Skips two intervals, the first of which may be cut short by a divider write, and returns the length of the third.
  task automatic tick_period(output int m);
    for (int k = 0; k < 3; k++)
    begin
      m = 0;
      do
      begin
        @(posedge clk);
        #1;
        m++;
      end while (ref_en !== 1'b1 && m < 40);
    end
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fails++;
      $display("timeout reached");
      wrap_up;
    end
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    int p;
    for (int i = 0; i < 8; i++)
    begin
      ext_kind[i] = 2'(i);
      ext_dest[i] = 8'(8'h10 + i);
      ext_flags[i] = 3'(i);
      proc_kind[i] = 2'(7 - i);
      proc_dest[i] = 8'(8'h80 + i);
      proc_flags[i] = 3'(7 - i);
    end
    repeat (4) @(posedge clk);
    #1;
    rstn = 1'b1;
    rdc("divider reset", ADDR_REF_DIV, 32'h0000_0003);
    rdc("node id reset", ADDR_NODE_ID, 32'h0000_0000);
    rdc("dir low reset", ADDR_DIR_LOW, 32'h0000_0000);
    rdc("dir high reset", ADDR_DIR_HIGH, 32'h0000_0000);
    rdc("debug cfg0 reset", ADDR_DBG_CFG0, 32'h0000_0000);
    rdc("debug cfg1 reset", ADDR_DBG_CFG1, 32'h0000_0000);
    check("ext dir reset", ext_dir, 32'h0000_0000);
    check("link nets reset", {ext_net, proc_net}, 32'h0000_0000);
    tick_period(p);
    check("tick period reset", 32'(p), 32'h0000_0003);
    $display("test reset values done");

    wr(ADDR_REF_DIV, 32'hFFFF_0005);
    rdc("divider", ADDR_REF_DIV, 32'h0000_0005);
    tick_period(p);
    check("tick period", 32'(p), 32'h0000_0005);
    rdc("test id", ADDR_TEST_ID, 32'h0A5C_3E71);
    wr(ADDR_USER_CODE, 32'hFFFF_FFFF);
    rdc("user code", ADDR_USER_CODE, {14'h1A2B, 18'h2_C3D4});
    $display("test divider and identity done");

    wr(ADDR_NODE_ID, 32'hFFFF_5A3C);
    rdc("node id", ADDR_NODE_ID, 32'h0000_5A3C);
    wr(ADDR_DIR_LOW, dirs[31:0]);
    wr(ADDR_DIR_HIGH, dirs[63:32]);
    rdc("dir low", ADDR_DIR_LOW, dirs[31:0]);
    rdc("dir high", ADDR_DIR_HIGH, dirs[63:32]);
    for (int d = 0; d < 16; d++)
      look(16'h5A3C ^ ((16'h0001 << d) | 16'h0001), 1'b0, dirs[d*4 +: 4]);
    look(16'h5A3C, 1'b1, 4'h0);
    $display("test routing done");

    wr(ADDR_DBG_CFG0, 32'hFFFF_FFFF);
    rdc("debug cfg0", ADDR_DBG_CFG0, 32'h0000_0003);
    wr(ADDR_DBG_CFG1, 32'h0000_0002);
    halted = 2'b01;
    repeat (6) @(posedge clk);
    #1;
    check("tile0 drives line", 32'(pin_oe), 32'h0000_0001);
    check("debug request", 32'(debug_req), 32'h0000_0003);
    rdc("origin tile0", ADDR_DBG_ORIGIN, 32'h0000_0001);
    halted = 2'b00;
    repeat (8) @(posedge clk);
    #1;
    check("request released", 32'(debug_req), 32'h0000_0000);
    halted = 2'b10;
    repeat (6) @(posedge clk);
    #1;
    check("tile1 not driving", {31'h0, pin_oe}, 32'h0000_0000);
    halted = 2'b00;
    ext_pull_n = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    check("pin request", 32'(debug_req), 32'h0000_0003);
    rdc("origin pin", ADDR_DBG_ORIGIN, 32'h0000_0010);
    ext_pull_n = 1'b1;
    wr(ADDR_DBG_CFG1, 32'h0000_0003);
    repeat (8) @(posedge clk);
    #1;
    halted = 2'b10;
    repeat (6) @(posedge clk);
    #1;
    check("tile1 drives line", 32'(pin_oe), 32'h0000_0001);
    rdc("origin tile1", ADDR_DBG_ORIGIN, 32'h0000_0002);
    halted = 2'b00;
    $display("test debug line done");

    for (int i = 0; i < 8; i++)
    begin
      wr(8'(ADDR_EXT_LINK0 + i), {20'hF_FFFF, 4'(15 - i), 2'b11, 2'(i), 4'hF});
      rdc("ext link", 8'(ADDR_EXT_LINK0 + i), {6'h00, ext_kind[i], ext_dest[i], 4'h0,
          4'(15 - i), 2'b00, 2'(i), 1'b0, ext_flags[i]});
      check("ext dir", 32'(ext_dir[i]), 32'(15 - i));
      check("ext net", 32'(ext_net[i]), 32'(i % 4));
      wr(8'(ADDR_PROC_LINK0 + i), {20'hF_FFFF, 4'hF, 2'b11, 2'(i), 4'hF});
      rdc("proc link", 8'(ADDR_PROC_LINK0 + i), {6'h00, proc_kind[i], proc_dest[i], 10'h000,
          2'(i), 1'b0, proc_flags[i]});
      check("proc net", 32'(proc_net[i]), 32'(i % 4));
    end
    foreach (unmapped[k])
    begin
      wr(unmapped[k], 32'hFFFF_FFFF);
      rdc("unmapped", unmapped[k], 32'h0000_0000);
    end
    $display("test link registers done");

    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    rdc("divider after reset", ADDR_REF_DIV, 32'h0000_0003);
    check("ext dir after reset", 32'(ext_dir), 32'h0000_0000);
    $display("test second reset done");
    wrap_up;
  end
endmodule
`default_nettype wire
